// ===== hdl/arics_defines.vh
// Constants shared by the read and idle command set logic
// How it works
// - Idle immediate opcode sets BSY, enters idle power state, clears BSY, interrupts.
// - The no-operation opcode always ends with an aborted command error.
// - Buffer-read returns current sector buffer contents using the PIO sector read handshake.
// - DMA read moves 1 to 256 sectors; a zero count means 256.
// - Start address comes from task file: head nibble, cylinder high, cylinder low, sector.
// - DMA read sets BSY, then on the media ack sets DRQ and clears BSY before any word arrives, raises DMAREQ while FIFO data ready.
// - DMA read interrupts only at completion or on an unrecoverable error.
// - DMA address registers end on last sector, or on failing sector after an error.
// - Multiple read moves blocks of the programmed size with DRQ only per block.
// - Count is sectors; the last partial block carries count modulo block size.
// - Multiple read aborts when multiple mode is unset or disabled.
// - Media error posted when the failing sector is acknowledged, even mid-block; DRQ still set and data still moved.
// - Multiple read interrupts each time DRQ is set at a block start.
// - Multiple read moves 1 to 256 sectors; a zero count means 256.
// - Failing sector's address stays in task file; flawed data stays in buffer until a later sector of the command overwrites it.
// - Only correctable errors let later blocks follow; others stop after that block.
// - Native max address opcode returns the native maximum LBA in the address registers when the LBA bit is set, else aborts.
// - PIO read: per sector set BSY, request the sector, on the media ack set DRQ, clear BSY, interrupt, then buffer data.
`ifndef ARICS_DEFINES_VH
`define ARICS_DEFINES_VH

`define ARICS_OP_IDLE_IMM_A 8'h95
`define ARICS_OP_IDLE_IMM_B 8'hE1
`define ARICS_OP_NOP 8'h00
`define ARICS_OP_RD_BUF 8'hE4
`define ARICS_OP_RD_DMA 8'hC8
`define ARICS_OP_RD_MULT 8'hC4
`define ARICS_OP_RD_SEC 8'h20
`define ARICS_OP_NATIVE_MAX 8'hF8

`define ARICS_DH_LBA_BIT 6
`define ARICS_FULL_COUNT 9'h100
`define ARICS_LAST_WORD 8'hFF
`define ARICS_NATIVE_MAX_LBA 28'h0FFFFFF

`define ARICS_ST_OK 2'h0
`define ARICS_ST_CORR 2'h1

`define ARICS_DATA_W 16
`define ARICS_FIFO_DEPTH 32
`define ARICS_FIFO_AW 5
`define ARICS_BUF_AW 8

`endif

// ===== hdl/arics_fifo.v
// Word FIFO between the media back end and the host side
`default_nettype none

module arics_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire core_clk,           // Clock
  input wire rst_n,              // Asynchronous reset, active low
  input wire in_valid,           // Write side word offered
  output reg in_ready,           // Write side can take a word
  input wire [WIDTH-1:0] in_data, // Write side word
  output reg out_valid,          // Read side word present
  input wire out_ready,          // Read side takes the word
  output wire [WIDTH-1:0] out_data // Read side word
);

  localparam [AW:0] FULL_COUNT = DEPTH[AW:0];

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;
  reg [AW:0] next_count;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_ptr];

  always @* begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Flags are registered so both ready and valid come from flip-flops
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= next_count;
      in_ready <= (next_count != FULL_COUNT);
      out_valid <= (next_count != {(AW+1){1'b0}});
    end
  end

endmodule // arics_fifo

`default_nettype wire

// ===== hdl/arics_sector_mem.v
// One-sector buffer memory with registered read data
`default_nettype none

module arics_sector_mem #(
  parameter WIDTH = 16,
  parameter AW = 8
) (
  input wire core_clk,            // Clock
  input wire wr_en,               // Write strobe
  input wire [AW-1:0] wr_addr,    // Write word index
  input wire [WIDTH-1:0] wr_data, // Write word
  input wire [AW-1:0] rd_addr,    // Read word index
  output reg [WIDTH-1:0] rd_data  // Read word, one cycle after address
);

  reg [WIDTH-1:0] mem [0:(1<<AW)-1];

  always @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule // arics_sector_mem

`default_nettype wire

// ===== hdl/arics_cmd.v
// Command sequencer for idle, no-op, buffer, DMA, multiple and native max reads
`include "arics_defines.vh"
`default_nettype none

module arics_cmd (
  input wire core_clk,                  // Clock, 125 MHz
  input wire rst_n,                     // Asynchronous reset, active low
  input wire cmd_valid,                 // Command register written, one cycle
  input wire [7:0] cmd_opcode,          // Command opcode
  input wire [7:0] cmd_dev_head,        // Drive/head register
  input wire [7:0] cmd_cyl_hi,          // Cylinder high register
  input wire [7:0] cmd_cyl_lo,          // Cylinder low register
  input wire [7:0] cmd_sec_num,         // Sector number register
  input wire [7:0] cmd_sec_count,       // Sector count register
  input wire [7:0] mult_block_size,     // Programmed block size, zero when disabled
  input wire host_status_rd,            // Host read of status, clears interrupt
  input wire host_rd_strobe,            // Host word read strobe, one per word
  input wire host_dmack_n,              // Host DMA acknowledge, active low
  input wire media_ack,                 // Back end sector status, one cycle
  input wire [1:0] media_status,        // 0 ok, 1 corrected, other fatal
  input wire media_valid,               // Back end word offered
  input wire [15:0] media_data,         // Back end word
  output reg media_req,                 // Sector fetch request, one cycle
  output reg [27:0] media_lba,          // Sector fetch address
  output wire media_ready,              // Back end word taken when high
  output reg [15:0] host_data,          // Word returned to host
  output reg host_word_ready,           // A word may be read now
  output reg dmareq,                    // DMA request to host
  output reg bsy,                       // Status busy
  output reg drq,                       // Status data request
  output reg err,                       // Status error
  output reg intrq,                     // Interrupt to host, level
  output reg err_abort,                 // Error register: aborted command
  output reg err_uncorr,                // Error register: uncorrectable data
  output reg err_corr,                  // Corrected data flag
  output reg power_idle,                // Drive is in idle power state
  output reg [27:0] tf_lba              // Address registers seen by the host
);

  localparam S_IDLE = 3'h0;
  localparam S_IDLE_PWR = 3'h1;
  localparam S_REQ = 3'h2;
  localparam S_ACK = 3'h3;
  localparam S_XFER = 3'h4;
  localparam S_RDBUF = 3'h5;

  function [8:0] count_of;
    input [7:0] raw;
    begin
      count_of = (raw == 8'h00) ? `ARICS_FULL_COUNT : {1'b0, raw};
    end
  endfunction

  function [8:0] min9;
    input [8:0] a;
    input [8:0] b;
    begin
      min9 = (a < b) ? a : b;
    end
  endfunction

  reg [2:0] state;
  reg mode_dma;
  reg mode_buf;
  reg fatal;
  reg err_hold;
  reg [27:0] lba;
  reg [8:0] remaining;
  reg [8:0] blk_size;
  reg [8:0] blk_left;
  reg [7:0] word_idx;

  wire fifo_out_valid;
  wire [15:0] fifo_out_data;
  wire [15:0] mem_rd_data;
  wire src_valid;
  wire take;
  wire last_word;
  wire [8:0] req_count;
  wire [27:0] cmd_lba;

  ////////////////////////////////////////////////////////////////////////////
  // Data path

  assign req_count = count_of(cmd_sec_count);
  assign cmd_lba = {cmd_dev_head[3:0], cmd_cyl_hi, cmd_cyl_lo, cmd_sec_num};
  assign src_valid = drq & (mode_buf ? (state == S_RDBUF) : (state == S_XFER) & fifo_out_valid);
  assign take = host_word_ready & host_rd_strobe & (~mode_dma | ~host_dmack_n);
  assign last_word = (word_idx == `ARICS_LAST_WORD);

  arics_fifo #(
    .WIDTH(`ARICS_DATA_W),
    .DEPTH(`ARICS_FIFO_DEPTH),
    .AW(`ARICS_FIFO_AW)
  ) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_valid(media_valid),
    .in_ready(media_ready),
    .in_data(media_data),
    .out_valid(fifo_out_valid),
    .out_ready(take & ~mode_buf),
    .out_data(fifo_out_data)
  );

  // Every word the host takes from the FIFO also lands in the sector buffer
  arics_sector_mem #(
    .WIDTH(`ARICS_DATA_W),
    .AW(`ARICS_BUF_AW)
  ) u_buf (
    .core_clk(core_clk),
    .wr_en(take & ~mode_buf),
    .wr_addr(word_idx),
    .wr_data(fifo_out_data),
    .rd_addr(word_idx),
    .rd_data(mem_rd_data)
  );

  // One gap cycle after each word lets the FIFO flags and buffer read settle
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_word_ready <= 1'b0;
      dmareq <= 1'b0;
      host_data <= 16'h0000;
    end else begin
      host_word_ready <= src_valid & ~take;
      dmareq <= src_valid & ~take & mode_dma;
      if (take) begin
        host_data <= mode_buf ? mem_rd_data : fifo_out_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      mode_dma <= 1'b0;
      mode_buf <= 1'b0;
      fatal <= 1'b0;
      err_hold <= 1'b0;
      lba <= 28'h0000000;
      remaining <= 9'h000;
      blk_size <= 9'h000;
      blk_left <= 9'h000;
      word_idx <= 8'h00;
      media_req <= 1'b0;
      media_lba <= 28'h0000000;
      bsy <= 1'b0;
      drq <= 1'b0;
      err <= 1'b0;
      intrq <= 1'b0;
      err_abort <= 1'b0;
      err_uncorr <= 1'b0;
      err_corr <= 1'b0;
      power_idle <= 1'b0;
      tf_lba <= 28'h0000000;
    end else begin
      media_req <= 1'b0;
      // A set later in this process wins over the host's clear
      if (host_status_rd) begin
        intrq <= 1'b0;
      end
      case (state)
        S_IDLE: begin
          if (cmd_valid) begin
            err <= 1'b0;
            err_abort <= 1'b0;
            err_uncorr <= 1'b0;
            err_corr <= 1'b0;
            fatal <= 1'b0;
            err_hold <= 1'b0;
            word_idx <= 8'h00;
            mode_dma <= 1'b0;
            mode_buf <= 1'b0;
            lba <= cmd_lba;
            tf_lba <= cmd_lba;
            remaining <= req_count;
            case (cmd_opcode)
              `ARICS_OP_IDLE_IMM_A, `ARICS_OP_IDLE_IMM_B: begin
                bsy <= 1'b1;
                state <= S_IDLE_PWR;
              end
              `ARICS_OP_RD_BUF: begin
                power_idle <= 1'b0;
                mode_buf <= 1'b1;
                bsy <= 1'b1;
                state <= S_RDBUF;
              end
              `ARICS_OP_RD_DMA: begin
                power_idle <= 1'b0;
                mode_dma <= 1'b1;
                blk_size <= req_count;
                blk_left <= req_count;
                bsy <= 1'b1;
                state <= S_REQ;
              end
              `ARICS_OP_RD_SEC: begin
                power_idle <= 1'b0;
                blk_size <= 9'h001;
                blk_left <= 9'h001;
                bsy <= 1'b1;
                state <= S_REQ;
              end
              `ARICS_OP_RD_MULT: begin
                power_idle <= 1'b0;
                if (mult_block_size == 8'h00) begin
                  err <= 1'b1;
                  err_abort <= 1'b1;
                  intrq <= 1'b1;
                end else begin
                  blk_size <= {1'b0, mult_block_size};
                  blk_left <= min9({1'b0, mult_block_size}, req_count);
                  bsy <= 1'b1;
                  state <= S_REQ;
                end
              end
              `ARICS_OP_NATIVE_MAX: begin
                if (cmd_dev_head[`ARICS_DH_LBA_BIT]) begin
                  tf_lba <= `ARICS_NATIVE_MAX_LBA;
                end else begin
                  err <= 1'b1;
                  err_abort <= 1'b1;
                end
                intrq <= 1'b1;
              end
              default: begin
                err <= 1'b1;
                err_abort <= 1'b1;
                intrq <= 1'b1;
              end
            endcase
          end
        end
        S_IDLE_PWR: begin
          power_idle <= 1'b1;
          bsy <= 1'b0;
          intrq <= 1'b1;
          state <= S_IDLE;
        end
        S_RDBUF: begin
          if (!drq) begin
            drq <= 1'b1;
            bsy <= 1'b0;
            intrq <= 1'b1;
          end else if (take) begin
            word_idx <= word_idx + 8'h01;
            if (last_word) begin
              drq <= 1'b0;
              state <= S_IDLE;
            end
          end
        end
        S_REQ: begin
          media_req <= 1'b1;
          media_lba <= lba;
          word_idx <= 8'h00;
          state <= S_ACK;
        end
        S_ACK: begin
          if (media_ack) begin
            if (media_status != `ARICS_ST_OK) begin
              err <= 1'b1;
              if (!err_hold) begin
                tf_lba <= lba;
                err_hold <= 1'b1;
              end
              if (media_status == `ARICS_ST_CORR) begin
                err_corr <= 1'b1;
              end else begin
                err_uncorr <= 1'b1;
                fatal <= 1'b1;
              end
            end else if (!err_hold) begin
              tf_lba <= lba;
            end
            if (!drq) begin
              drq <= 1'b1;
              bsy <= 1'b0;
              if (!mode_dma) begin
                intrq <= 1'b1;
              end
            end
            state <= S_XFER;
          end
        end
        S_XFER: begin
          if (take) begin
            word_idx <= word_idx + 8'h01;
            if (last_word) begin
              remaining <= remaining - 9'h001;
              blk_left <= blk_left - 9'h001;
              lba <= lba + 28'h0000001;
              if (remaining == 9'h001 || (fatal && (blk_left == 9'h001 || mode_dma))) begin
                drq <= 1'b0;
                bsy <= 1'b0;
                if (mode_dma) begin
                  intrq <= 1'b1;
                end
                state <= S_IDLE;
              end else if (blk_left == 9'h001) begin
                drq <= 1'b0;
                bsy <= 1'b1;
                blk_left <= min9(blk_size, remaining - 9'h001);
                state <= S_REQ;
              end else begin
                state <= S_REQ;
              end
            end
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

endmodule // arics_cmd

`default_nettype wire

// ===== verification/arics_cmd_monitor.sv
// Concurrent checks on the command sequencer ports
`include "arics_defines.vh"
`default_nettype none

module arics_cmd_monitor (
  input wire logic core_clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic cmd_valid, // Command strobe
  input wire logic [7:0] cmd_opcode, // Opcode
  input wire logic [7:0] cmd_dev_head, // Drive/head
  input wire logic [7:0] mult_block_size, // Block size
  input wire logic host_rd_strobe, // Word strobe
  input wire logic host_word_ready, // Word ready
  input wire logic media_req, // Fetch request
  input wire logic dmareq, // DMA request
  input wire logic bsy, // Busy
  input wire logic drq, // Data request
  input wire logic intrq, // Interrupt
  input wire logic err_abort, // Aborted
  input wire logic power_idle, // Idle power state
  input wire logic [27:0] tf_lba // Address registers
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  logic dma_mode;
  wire take = cmd_valid && !bsy && !drq;
  wire is_f8 = cmd_opcode == `ARICS_OP_NATIVE_MAX;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dma_mode <= 1'b0;
    end else if (take) begin
      dma_mode <= cmd_opcode == `ARICS_OP_RD_DMA;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  sequence s_idle_done;
    bsy ##1 !bsy && power_idle && intrq;
  endsequence
  sequence s_abort;
    err_abort && intrq && !bsy;
  endsequence
  a_idle_steps:
    assert property (take && (cmd_opcode == `ARICS_OP_IDLE_IMM_A
      || cmd_opcode == `ARICS_OP_IDLE_IMM_B) |=> s_idle_done)
    else $error("idle immediate steps wrong");
  a_nop_abort:
    assert property (take && cmd_opcode == `ARICS_OP_NOP |=> s_abort)
    else $error("no-op not aborted");
  a_mult_unset:
    assert property (take && cmd_opcode == `ARICS_OP_RD_MULT && mult_block_size == 8'h00
      |=> s_abort)
    else $error("multiple read without block size not aborted");
  a_native_value:
    assert property (take && is_f8 && cmd_dev_head[6]
      |=> tf_lba == `ARICS_NATIVE_MAX_LBA && intrq)
    else $error("native max address wrong");
  a_native_nolba:
    assert property (take && is_f8 && !cmd_dev_head[6] |=> s_abort)
    else $error("native max without lba bit not aborted");
  a_read_fetch:
    assert property (take && (cmd_opcode == `ARICS_OP_RD_DMA || (cmd_opcode ==
      `ARICS_OP_RD_MULT && mult_block_size != 8'h00)) |=> bsy ##1 media_req)
    else $error("read did not fetch first sector");
  a_dma_quiet:
    assert property (dmareq |-> !intrq && drq && !bsy)
    else $error("dma request with interrupt or bad status");
  a_word_gap:
    assert property (host_word_ready && host_rd_strobe |=> !host_word_ready)
    else $error("word ready did not drop after a word");
  a_block_irq:
    assert property ($rose(drq) && !dma_mode |-> intrq)
    else $error("no interrupt at block start");
endmodule // arics_cmd_monitor

bind arics_cmd arics_cmd_monitor u_mon (.core_clk, .rst_n, .cmd_valid, .cmd_opcode,
  .cmd_dev_head, .mult_block_size, .host_rd_strobe, .host_word_ready, .media_req,
  .dmareq, .bsy, .drq, .intrq, .err_abort, .power_idle, .tf_lba);

`default_nettype wire

// ===== verification/arics_host_model.sv
// Host side model that reads words by PIO strobe or DMA acknowledge
`default_nettype none

module arics_host_model (
  input wire logic core_clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic host_word_ready, // Word may be read
  input wire logic [15:0] host_data, // Word from drive
  input wire logic dma, // Command uses DMA
  input wire logic stall, // Hold off reading
  output logic host_rd_strobe, // Word strobe
  output logic host_dmack_n // DMA acknowledge, active low
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] rx[$];
  logic took;
  wire acc = host_rd_strobe && host_word_ready && (!dma || !host_dmack_n);
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_rd_strobe <= 1'b0;
      host_dmack_n <= 1'b1;
      took <= 1'b0;
    end else begin
      host_dmack_n <= !dma;
      took <= acc;
      if (took) begin
        rx.push_back(host_data);
      end
      // Strobe is held until the drive takes it
      if (acc) begin
        host_rd_strobe <= 1'b0;
      end else if (!stall && host_word_ready && (!dma || !host_dmack_n)) begin
        host_rd_strobe <= 1'b1;
      end
    end
  end
endmodule // arics_host_model

`default_nettype wire

// ===== verification/arics_cmd_bench.sv
// Self-checking bench for the read and idle command sequencer
`include "arics_defines.vh"
`default_nettype none

module arics_cmd_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst_n, cmd_valid, host_status_rd, media_ack, media_valid, dma, stall;
  logic [7:0] cmd_opcode, cmd_dev_head, cmd_cyl_hi, cmd_cyl_lo, cmd_sec_num, cmd_sec_count;
  logic [7:0] mult_block_size;
  logic [1:0] media_status, bad_st;
  logic [15:0] media_data, host_data;
  logic host_rd_strobe, host_dmack_n, media_req, media_ready, host_word_ready, dmareq;
  logic bsy, drq, drq_q, err, intrq, err_abort, err_uncorr, err_corr, power_idle;
  logic [27:0] media_lba, tf_lba, bad_lba;
  int n_fail, n_compared, n_drq, drq0;
  arics_cmd dut (.core_clk, .rst_n, .cmd_valid, .cmd_opcode, .cmd_dev_head, .cmd_cyl_hi,
    .cmd_cyl_lo, .cmd_sec_num, .cmd_sec_count, .mult_block_size, .host_status_rd,
    .host_rd_strobe, .host_dmack_n, .media_ack, .media_status, .media_valid, .media_data,
    .media_req, .media_lba, .media_ready, .host_data, .host_word_ready, .dmareq, .bsy, .drq,
    .err, .intrq, .err_abort, .err_uncorr, .err_corr, .power_idle, .tf_lba);
  arics_host_model host (.core_clk, .rst_n, .host_word_ready, .host_data, .dma, .stall,
    .host_rd_strobe, .host_dmack_n);
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (rst_n !== 1'b1) begin
      drq_q <= 1'b0;
      n_drq <= 0;
    end else begin
      drq_q <= drq;
      if (drq === 1'b1 && drq_q === 1'b0) n_drq <= n_drq + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Media back end: ack, then one sector of 256 words tagged by address
  task automatic serve(input logic [27:0] lba);
    media_ack <= 1'b1;
    media_status <= (lba === bad_lba) ? bad_st : `ARICS_ST_OK;
    @(posedge core_clk);
    media_ack <= 1'b0;
    for (int i = 0; i < 256; i++) begin
      media_valid <= 1'b1;
      media_data <= {lba[7:0], i[7:0]};
      do @(posedge core_clk); while (media_ready !== 1'b1);
    end
    media_valid <= 1'b0;
    media_data <= ~media_data;
  endtask
  initial begin
    media_ack = 1'b0;
    media_valid = 1'b0;
    media_status = 2'h0;
    media_data = 16'h0000;
    forever begin
      @(posedge core_clk);
      if (media_req === 1'b1) serve(media_lba);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input bit ok, input string msg);
    n_compared++;
    if (!ok) begin
      n_fail++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic cmd(input logic [7:0] op, dh, input logic [23:0] a, input logic [7:0] cnt);
    @(posedge core_clk);
    host_status_rd <= 1'b1;
    @(posedge core_clk);
    host_status_rd <= 1'b0;
    cmd_valid <= 1'b1;
    cmd_opcode <= op;
    cmd_dev_head <= dh;
    {cmd_cyl_hi, cmd_cyl_lo, cmd_sec_num} <= a;
    cmd_sec_count <= cnt;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    host.rx.delete();
    drq0 = n_drq;
  endtask
  task automatic wait_done;
    int k;
    k = 0;
    repeat (2) @(posedge core_clk);
    while ((bsy !== 1'b0 || drq !== 1'b0) && k < 5000) begin
      @(posedge core_clk);
      k++;
    end
    repeat (2) @(posedge core_clk);
    chk(k < 5000, "command never finished");
  endtask
  task automatic chk_words(input int n, input logic [27:0] lba);
    logic [27:0] s;
    chk(host.rx.size() == n, "word count");
    for (int k = 0; k < host.rx.size() && k < n; k++) begin
      s = lba + 28'(k / 256);
      chk(host.rx[k] === {s[7:0], k[7:0]}, "word value");
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_idle;
    for (int i = 0; i < 2; i++) begin
      cmd(i ? `ARICS_OP_IDLE_IMM_B : `ARICS_OP_IDLE_IMM_A, 8'hA0, 24'h0, 8'h00);
      wait_done;
      chk(power_idle === 1'b1 && intrq === 1'b1 && err === 1'b0, "idle");
    end
  endtask
  task automatic t_abort;
    logic [7:0] ops[3] = '{`ARICS_OP_NOP, `ARICS_OP_NATIVE_MAX, `ARICS_OP_RD_MULT};
    mult_block_size <= 8'h00;
    for (int i = 0; i < 3; i++) begin
      cmd(ops[i], 8'hA0, 24'h0, 8'h01);
      wait_done;
      chk(err_abort === 1'b1 && intrq === 1'b1, "abort");
    end
    cmd(`ARICS_OP_NATIVE_MAX, 8'hE0, 24'h0, 8'h00);
    wait_done;
    chk(tf_lba === `ARICS_NATIVE_MAX_LBA && err === 1'b0, "native max");
  endtask
  task automatic t_dma(input logic [27:0] bad, input logic [1:0] st, input logic [27:0] last);
    bad_lba <= bad;
    bad_st <= st;
    dma <= 1'b1;
    stall <= 1'b1;
    cmd(`ARICS_OP_RD_DMA, 8'hE1, 24'h234567, 8'h02);
    repeat (120) @(posedge core_clk);
    chk(media_ready === 1'b0 && dmareq === 1'b1, "full buffer");
    stall <= 1'b0;
    wait_done;
    chk(intrq === 1'b1 && err === (st != `ARICS_ST_OK), "dma end");
    chk(err_uncorr === (st != `ARICS_ST_OK), "dma error kind");
    chk(tf_lba === last, "dma last address");
    chk_words((st == `ARICS_ST_OK) ? 512 : 256, 28'h1234567);
    dma <= 1'b0;
  endtask
  task automatic t_mult(input logic [7:0] op, input logic [27:0] bad, input logic [1:0] st,
    input logic [7:0] cnt, input int blocks, input int words);
    mult_block_size <= 8'h02;
    bad_lba <= bad;
    bad_st <= st;
    cmd(op, 8'hE0, 24'h000100, cnt);
    wait_done;
    chk(n_drq - drq0 == blocks, "block count");
    chk(tf_lba === bad && err === 1'b1, "error address");
    chk(err_corr === (st == `ARICS_ST_CORR) && err_uncorr === (st != `ARICS_ST_CORR),
      "error kind");
    chk_words(words, 28'h100);
  endtask
  task automatic t_rdbuf;
    cmd(`ARICS_OP_RD_BUF, 8'hA0, 24'h0, 8'h00);
    wait_done;
    chk_words(256, 28'h101);
  endtask
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    {cmd_valid, host_status_rd, dma, stall} = 4'h0;
    {cmd_opcode, cmd_dev_head, cmd_cyl_hi, cmd_cyl_lo} = 32'h0000_0000;
    {cmd_sec_num, cmd_sec_count, mult_block_size} = 24'h00_0000;
    bad_lba = 28'hFFFFFFF;
    bad_st = 2'h0;
    n_fail = 0;
    n_compared = 0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    t_idle;
    $display("idle test done");
    t_abort;
    $display("abort test done");
    t_dma(28'hFFFFFFF, `ARICS_ST_OK, 28'h1234568);
    $display("dma test done");
    t_dma(28'h1234567, 2'h3, 28'h1234567);
    $display("fatal dma test done");
    t_mult(`ARICS_OP_RD_MULT, 28'h101, `ARICS_ST_CORR, 8'h03, 2, 768);
    $display("corrected multiple test done");
    t_mult(`ARICS_OP_RD_SEC, 28'h101, `ARICS_ST_CORR, 8'h02, 2, 512);
    $display("read sectors test done");
    t_mult(`ARICS_OP_RD_MULT, 28'h100, 2'h2, 8'h04, 1, 512);
    $display("fatal multiple test done");
    t_rdbuf;
    $display("read buffer test done");
    conclude;
  end
  initial begin
    #200000;
    n_fail++;
    $display("BAD %0t watchdog expired", $time);
    conclude;
  end
endmodule // arics_cmd_bench

`default_nettype wire
